// *** cpbc_top.sv ***
`timescale 1ns/1ps
// Purpose: power-down, wakeup filter, timer link and bit clock
// Assumes: protocol engine outside; AXI4-Lite register access
// Notes: registers are bytes in the low lane of each word

module cpbc_top import cpbc_pkg::*; #(
  parameter int ADDR_W = 9
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // register bus read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cpu low-power state
  input wire logic cpu_stop,
  input wire logic cpu_wait,
  // module clock sources as enables
  input wire logic crystal_osc_clock,
  input wire logic system_bus_clock,
  // protocol engine side
  input wire logic engine_busy,
  input wire logic engine_tx,
  input wire logic frame_ok,
  input wire logic rx_wr_en,
  input wire logic [3:0] rx_wr_idx,
  input wire logic [7:0] rx_wr_data,
  output logic abort_frame,
  output logic bit_start,
  output logic sample_point,
  // bus pins
  input wire logic bus_receive_pin,
  output logic bus_transmit_pin,
  // capture timer and wakeup
  output logic timer_link_out,
  output logic wakeup_irq
);
  typedef enum logic [1:0] {
    RG_CTRL,
    RG_BG,
    RG_BUF,
    RG_NONE
  } cpbc_region_e;

  typedef struct packed {
    logic [7:0] mc0;
    logic [7:0] mc1;
    logic [7:0] bt0;
    logic [7:0] bt1;
    logic sleep_acknowledge;
    logic wake;
    logic pd;
    logic tx;
    logic link_pend;
    logic link_pulse;
    logic link_out;
    logic irq;
    logic [FILT_W-1:0] filt;
    logic [3:0][15:0][7:0] mbuf;
    logic [15:0][7:0] bg;
    logic aw_got;
    logic w_got;
    logic [6:0] aw_idx;
    logic [7:0] w_byte;
    logic w_en;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rbyte;
    logic [6:0] ar_idx;
  } cpbc_top_s;

  localparam cpbc_top_s RST_S = '{mc0: MC0_RST, mc1: MC1_RST, bt0: BT0_RST,
    bt1: BT1_RST, tx: 1'b1, default: '0};

  cpbc_top_s s, n;
  logic pd_now;
  logic wake_hit;
  cpbc_bt_if bt();

  ////////////////////////////////////////////////////////////////////
  // window decode; upper index bits fall outside the 128 bytes
  function automatic cpbc_region_e region(logic [6:0] i);
    if (i >= win_idx(OFS_RX_FOREGROUND_BUFFER)) begin
      return RG_BUF;
    end else if (i >= win_idx(OFS_RXBG) && i < win_idx(OFS_RXBG) + 7'h10) begin
      return RG_BG;
    end else if (i <= win_idx(OFS_STAT)) begin
      return RG_CTRL;
    end else begin
      return RG_NONE;
    end
  endfunction

  // read mux for one byte
  function automatic logic [7:0] rd_byte(cpbc_top_s st, logic [6:0] i);
    logic [7:0] r;
    r = 8'h00;
    unique case (region(i))
      RG_CTRL: begin
        if (i == win_idx(OFS_MC0)) r = st.mc0;
        if (i == win_idx(OFS_MC1)) r = st.mc1;
        if (i == win_idx(OFS_BT0)) r = st.bt0;
        if (i == win_idx(OFS_BT1)) r = st.bt1;
        if (i == win_idx(OFS_STAT)) r = {5'h00, st.pd, st.wake, st.sleep_acknowledge};
      end
      RG_BG: begin
        r = st.mc0[MC0_TEST] ? st.bg[i[3:0]] : 8'h00;
      end
      RG_BUF: begin
        r = st.mbuf[i[5:4]][i[3:0]];
      end
      RG_NONE: begin
        r = 8'h00;
      end
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    n = s;
    // stop, or wait with the enable bit, powers down
    pd_now = cpu_stop || (cpu_wait && s.mc1[MC1_WPDE]);
    n.pd = pd_now;
    wake_hit = 1'b0;

    // write address and data are taken in either order
    if (s.awready && s_axi_awvalid) begin
      n.aw_got = 1'b1;
      n.aw_idx = s_axi_awaddr[8:2];
    end
    if (s.wready && s_axi_wvalid) begin
      n.w_got = 1'b1;
      n.w_byte = s_axi_wdata[7:0];
      n.w_en = s_axi_wstrb[0];
    end
    // a pending write waits out power-down rather than landing
    if (s.aw_got && s.w_got && !s.bvalid && !s.pd) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      unique case (region(s.aw_idx))
        RG_CTRL: begin
          if (s.w_en) begin
            if (s.aw_idx == win_idx(OFS_MC0)) n.mc0 = s.w_byte;
            if (s.aw_idx == win_idx(OFS_MC1)) n.mc1 = s.w_byte;
            if (s.aw_idx == win_idx(OFS_BT0)) n.bt0 = s.w_byte;
            if (s.aw_idx == win_idx(OFS_BT1)) n.bt1 = s.w_byte;
            if (s.aw_idx == win_idx(OFS_STAT) && s.w_byte[ST_WAKE]) n.wake = 1'b0;
          end
        end
        RG_BG: begin
          n.bresp = RESP_OKAY;
        end
        RG_BUF: begin
          // foreground receive buffer ignores writes
          if (s.w_en && s.aw_idx[5:4] != 2'h0) begin
            n.mbuf[s.aw_idx[5:4]][s.aw_idx[3:0]] = s.w_byte;
          end
        end
        RG_NONE: begin
          n.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    n.awready = !pd_now && !n.aw_got && !n.bvalid;
    n.wready = !pd_now && !n.w_got && !n.bvalid;

    // read: one outstanding, answered the next cycle
    if (s.arready && s_axi_arvalid) begin
      n.ar_idx = s_axi_araddr[8:2];
      n.rvalid = 1'b1;
      n.rbyte = rd_byte(s, s_axi_araddr[8:2]);
      n.rresp = (region(s_axi_araddr[8:2]) == RG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    n.arready = !pd_now && !n.rvalid;

    // sleep handshake follows the request once the engine is idle
    if (n.mc0[MC0_SLPRQ] && !engine_busy && !pd_now) begin
      n.sleep_acknowledge = 1'b1;
    end
    if (!n.mc0[MC0_SLPRQ]) begin
      n.sleep_acknowledge = 1'b0;
    end

    // dominant level while asleep wakes; filter needs a steady run
    n.filt = '0;
    if (s.sleep_acknowledge && !bus_receive_pin) begin
      if (!s.mc1[MC1_WFM] || s.filt == WAKE_FILT_LAST) begin
        wake_hit = 1'b1;
      end else begin
        n.filt = s.filt + 1'b1;
      end
    end
    if (wake_hit) begin
      // set after the software clear so a same-cycle wake is kept
      n.wake = 1'b1;
      n.sleep_acknowledge = 1'b0;
      n.mc0[MC0_SLPRQ] = 1'b0;
    end
    n.irq = (s.irq && n.wake && n.mc1[MC1_WIE])
      || (wake_hit && s.sleep_acknowledge && s.mc1[MC1_WIE]);

    // engine fills the background buffer, good frame copies it
    if (rx_wr_en && !s.pd) begin
      n.bg[rx_wr_idx] = rx_wr_data;
    end
    if (frame_ok && !s.pd && !s.sleep_acknowledge) begin
      n.mbuf[0] = s.bg;
    end

    // link pulse spans bit start to bit start: exactly one bit
    if (bt.bit_start) begin
      n.link_pulse = s.link_pend;
      n.link_pend = 1'b0;
    end
    // frame_ok covers received and own sent frames alike
    if (frame_ok && !s.pd) begin
      n.link_pend = 1'b1;
    end
    if (pd_now) begin
      n.link_pend = 1'b0;
      n.link_pulse = 1'b0;
    end
    n.link_out = n.link_pulse && n.mc0[MC0_TLNK];

    // recessive while powered down or asleep
    n.tx = (pd_now || n.sleep_acknowledge) ? 1'b1 : engine_tx;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= RST_S;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bit timer hookup; tick rate bounds the 10 kbps to 1 Mbps span
  assign bt.tick = s.mc1[MC1_CSEL] ? system_bus_clock : crystal_osc_clock;
  assign bt.run = !s.pd && !s.sleep_acknowledge;
  assign bt.rx_in = bus_receive_pin;
  assign bt.presc = s.bt0[5:0];
  assign bt.resync_jump_width = s.bt0[7:6];
  assign bt.first_segment_length = s.bt1[3:0];
  assign bt.second_segment_length = s.bt1[6:4];

  cpbc_bit_timer u_bit_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .bt(bt.tmr)
  );

  // outputs
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = {24'h000000, s.rbyte};
  assign abort_frame = s.pd;
  assign bit_start = bt.bit_start;
  assign sample_point = bt.sample_pt;
  assign bus_transmit_pin = s.tx;
  assign timer_link_out = s.link_out;
  assign wakeup_irq = s.irq;

  ////////////////////////////////////////////////////////////////////
  pd_entry_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_stop || (cpu_wait && s.mc1[MC1_WPDE])) |=> abort_frame)
    else $error("power-down not entered");
  abort_now_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(abort_frame) |-> !s.link_pend && !s.link_pulse)
    else $error("frame activity survived power-down");
  tx_recessive_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    abort_frame |-> bus_transmit_pin)
    else $error("transmit pin dominant in power-down");
  no_access_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    abort_frame |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("bus accepted during power-down");
  wake_filter_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    wake_hit && s.mc1[MC1_WFM] |-> s.filt == WAKE_FILT_LAST)
    else $error("filtered wake before glitch time");
  link_start_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(s.link_pulse) |-> $past(bt.bit_start) || $past(s.pd) || abort_frame)
    else $error("link pulse edge off bit boundary");
  link_gate_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    timer_link_out |-> s.mc0[MC0_TLNK] && s.link_pulse)
    else $error("link output while disabled");
  wake_irq_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(wakeup_irq) |-> $past(s.sleep_acknowledge) && $past(s.mc1[MC1_WIE]))
    else $error("wake interrupt without sleep ack");
  bg_test_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    s.rvalid && region(s.ar_idx) == RG_BG && !s.mc0[MC0_TEST] |-> s.rbyte == 8'h00)
    else $error("background buffer read outside test");
endmodule

// *** cpbc_pkg.sv ***
// Purpose: shared constants for the bit clock and power block
// Assumes: one 200 MHz clock, byte registers on 32-bit words
// Notes: offsets are printed byte offsets; bus address is 4x index
package cpbc_pkg;
  // clock and wakeup glitch filter timing
  localparam int CLK_MHZ = 200;
  localparam int WAKE_FILT_NS = 2000;
  localparam int WAKE_FILT_CYC = (WAKE_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_W = $clog2(WAKE_FILT_CYC);
  localparam logic [FILT_W-1:0] WAKE_FILT_LAST = FILT_W'(WAKE_FILT_CYC - 1);
  // window layout, printed offsets
  localparam int WIN_BYTES = 128;
  localparam logic [11:0] WIN_BASE = 12'h100;
  localparam logic [11:0] OFS_MC0 = 12'h100;
  localparam logic [11:0] OFS_MC1 = 12'h101;
  localparam logic [11:0] OFS_BT0 = 12'h102;
  localparam logic [11:0] OFS_BT1 = 12'h103;
  localparam logic [11:0] OFS_STAT = 12'h104;
  localparam logic [11:0] OFS_RXBG = 12'h120;
  localparam logic [11:0] OFS_RX_FOREGROUND_BUFFER = 12'h140;
  localparam logic [11:0] OFS_TXA = 12'h150;
  localparam logic [11:0] OFS_TXB = 12'h160;
  localparam logic [11:0] OFS_TXC = 12'h170;
  // field positions
  localparam int MC0_SLPRQ = 0;
  localparam int MC0_TLNK = 1;
  localparam int MC0_TEST = 2;
  localparam int MC1_WFM = 0;
  localparam int MC1_CSEL = 1;
  localparam int MC1_WPDE = 2;
  localparam int MC1_WIE = 3;
  localparam int ST_SLEEP_ACKNOWLEDGE = 0;
  localparam int ST_WAKE = 1;
  localparam int ST_PD = 2;
  // reset values: shortest legal segments
  localparam logic [7:0] MC0_RST = 8'h00;
  localparam logic [7:0] MC1_RST = 8'h00;
  localparam logic [7:0] BT0_RST = 8'h00;
  localparam logic [7:0] BT1_RST = 8'h13;
  // segment floors in quanta
  localparam logic [5:0] FIRST_SEGMENT_LENGTH_MIN_TQ = 6'h04;
  localparam logic [5:0] SECOND_SEGMENT_LENGTH_MIN_TQ = 6'h02;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // printed offset to window index
  function automatic logic [6:0] win_idx(logic [11:0] ofs);
    return 7'(ofs - WIN_BASE);
  endfunction
endpackage

// *** cpbc_bt_if.sv ***
`timescale 1ns/1ps
// Purpose: config and strobes between control and bit timer
// Assumes: single clock domain
// Notes: tick is the selected module clock as an enable
interface cpbc_bt_if;
  logic tick;
  logic run;
  logic rx_in;
  logic [5:0] presc;
  logic [3:0] first_segment_length;
  logic [2:0] second_segment_length;
  logic [1:0] resync_jump_width;
  logic tq_tick;
  logic bit_start;
  logic sample_pt;
  modport cfg(output tick, run, rx_in, presc, first_segment_length, second_segment_length, resync_jump_width,
    input tq_tick, bit_start, sample_pt);
  modport tmr(input tick, run, rx_in, presc, first_segment_length, second_segment_length, resync_jump_width,
    output tq_tick, bit_start, sample_pt);
endinterface

// *** cpbc_bit_timer.sv ***
`timescale 1ns/1ps
// Purpose: quantum prescaler and bit segment sequencer
// Assumes: fields hold length minus one
// Notes: one resync per bit, no hard sync
module cpbc_bit_timer import cpbc_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // config and strobes
  cpbc_bt_if.tmr bt
);
  typedef struct packed {
    logic [5:0] pcnt;
    logic [5:0] pos;
    logic [5:0] ext;
    logic [5:0] shrt;
    logic done;
    logic rx_prev;
    logic tq_tick;
    logic bit_start;
    logic sample_pt;
  } cpbc_bt_s;

  cpbc_bt_s s, n;
  logic [5:0] l1;
  logic [5:0] l2;
  logic [5:0] jw;

  function automatic logic [5:0] umax(logic [5:0] a, logic [5:0] b);
    return (a > b) ? a : b;
  endfunction

  function automatic logic [5:0] umin(logic [5:0] a, logic [5:0] b);
    return (a < b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // segment lengths, floored so a bad field cannot break the bit
  assign l1 = umax(6'(bt.first_segment_length) + 6'h01, FIRST_SEGMENT_LENGTH_MIN_TQ) + s.ext;
  assign l2 = umax(6'(bt.second_segment_length) + 6'h01, SECOND_SEGMENT_LENGTH_MIN_TQ) - s.shrt;
  assign jw = 6'(bt.resync_jump_width) + 6'h01;

  // quantum and segment sequencing
  always_comb begin
    n = s;
    n.tq_tick = 1'b0;
    n.bit_start = 1'b0;
    n.sample_pt = 1'b0;
    n.rx_prev = bt.rx_in;
    if (!bt.run) begin
      n.pcnt = 6'h00;
      n.pos = 6'h00;
      n.ext = 6'h00;
      n.shrt = 6'h00;
      n.done = 1'b0;
    end else begin
      // recessive to dominant edge outside sync segment
      if (s.rx_prev && !bt.rx_in && !s.done && s.pos != 6'h00) begin
        n.done = 1'b1;
        if (s.pos <= l1) begin
          n.ext = umin(s.pos, jw);
        end else begin
          n.shrt = umin(jw, l1 + l2 - s.pos);
        end
      end
      if (bt.tick) begin
        if (s.pcnt >= bt.presc) begin
          n.pcnt = 6'h00;
          n.tq_tick = 1'b1;
          if (s.pos >= l1 + l2) begin
            n.pos = 6'h00;
            n.bit_start = 1'b1;
            n.ext = 6'h00;
            n.shrt = 6'h00;
            n.done = 1'b0;
          end else begin
            n.pos = s.pos + 6'h01;
            n.sample_pt = (s.pos == l1);
          end
        end else begin
          n.pcnt = s.pcnt + 6'h01;
        end
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{rx_prev: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  assign bt.tq_tick = s.tq_tick;
  assign bt.bit_start = s.bit_start;
  assign bt.sample_pt = s.sample_pt;

  ////////////////////////////////////////////////////////////////////
  sync_first_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    s.bit_start |-> s.pos == 6'h00 && s.tq_tick)
    else $error("bit start outside sync segment");
  seg1_span_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    s.sample_pt |-> s.pos >= 6'h05 && s.pos <= 6'h15)
    else $error("sample point outside first segment range");
  jump_width_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    s.ext <= 6'h04 && s.shrt <= 6'h04)
    else $error("resync step above four quanta");
  bit_total_a:
  assert property (@(posedge aclk) disable iff (!aresetn)
    s.pos <= 6'h1C)
    else $error("bit longer than allowed quanta");
endmodule

// *** cpbc_bus_node.sv ***
// Purpose: far-side node sharing the bus wire with the block
// Assumes: wired-and bus, recessive high through a pull-up
// Notes: drives dominant only when the bench asks for it
`timescale 1ns/1ps
module cpbc_bus_node (
  // clock
  input wire logic aclk,
  // wire levels
  input wire logic tx_level,
  output logic rx_level
);
  logic dom_q = 1'b0;
  ////////////////////////////////////////////////////////////////////////////////
  // wired-and: any dominant driver pulls the line low, else pull-up wins
  assign rx_level = tx_level & ~dom_q;
  // hold the line dominant for n cycles, then release it
  task automatic drive_dominant(input int n);
    dom_q <= 1'b1;
    repeat (n) @(posedge aclk);
    dom_q <= 1'b0;
  endtask
endmodule

// *** testbench.sv ***
// Purpose: self-checking bench for the power, wakeup, link and bit clock block
// Assumes: registers reached over the AXI4-Lite slave port
// Notes: read and write answers are checked from a queue of notes
`timescale 1ns/1ps
module testbench import cpbc_pkg::*; ;
  logic aclk = 0, aresetn = 0;
  logic [8:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, p;
  logic cpu_stop = 0, cpu_wait = 0, osc = 0, engine_busy = 0, engine_tx = 1;
  logic frame_ok = 0, rx_wr_en = 0, csel;
  logic [3:0] rx_wr_idx = 0, t1;
  logic [7:0] rx_wr_data = 0;
  logic [2:0] prot = 0;
  logic [3:0] strb = 4'hF;
  logic bus_clk = 1;
  logic [2:0] t2;
  logic abort_frame, bit_start, sample_point, rx_pin, tx_pin, link, wake_irq;
  logic [31:0] lfsr = 32'h9E37;
  logic [33:0] exp_q[$];
  int mismatches = 0, checks_done = 0, cyc = 0, n, ec, nb, ns;
  ////////////////////////////////////////////////////////////////////////////////
  // clock, oscillator enable every other cycle, bus clock enable held high
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) osc <= ~osc;
  cpbc_top #(.ADDR_W(9)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
    .crystal_osc_clock(osc), .system_bus_clock(bus_clk), .engine_busy(engine_busy),
    .engine_tx(engine_tx), .frame_ok(frame_ok), .rx_wr_en(rx_wr_en),
    .rx_wr_idx(rx_wr_idx), .rx_wr_data(rx_wr_data), .abort_frame(abort_frame),
    .bit_start(bit_start), .sample_point(sample_point), .bus_receive_pin(rx_pin),
    .bus_transmit_pin(tx_pin), .timer_link_out(link), .wakeup_irq(wake_irq));
  cpbc_bus_node node (.aclk(aclk), .tx_level(tx_pin), .rx_level(rx_pin));
  ////////////////////////////////////////////////////////////////////////////////
  // pseudo-random source for register payloads and segment lengths
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  // single comparison point
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // hang guard: longest test is a few thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      end_sim();
    end
  end
  // answers are popped in order; only one access is ever in flight
  always @(posedge aclk) begin
    if (bvalid && bready) check("bresp", {bresp, 32'h0}, exp_q.pop_front());
    if (rvalid && rready) check("rdata", {rresp, rdata}, exp_q.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////////////
  // bus master: releases each channel at the edge that takes it
  task automatic wr(input logic [11:0] ofs, input logic [7:0] v);
    exp_q.push_back({RESP_OKAY, 32'h0});
    @(posedge aclk);
    awaddr <= 9'((ofs - WIN_BASE) << 2);
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] ofs, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge aclk);
    araddr <= 9'((ofs - WIN_BASE) << 2);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  // settle new timing, send one good frame, count link-high cycles over 3 bits
  task automatic link_len(input int e);
    n = 0;
    nb = 0;
    ns = 0;
    repeat (250) @(posedge aclk);
    frame_ok <= 1'b1;
    @(posedge aclk);
    frame_ok <= 1'b0;
    repeat (3 * ec) begin
      @(posedge aclk);
      if (link === 1'b1) n++;
      if (bit_start === 1'b1) nb++;
      if (sample_point === 1'b1) ns++;
    end
    check("link_cycles", 34'(n), 34'(e));
    check("bit_starts", 34'(nb), 34'h3);
    check("sample_points", 34'(ns), 34'h3);
  endtask
  task automatic pd_step(input logic s, input logic w, input logic e);
    @(posedge aclk);
    cpu_stop <= s;
    cpu_wait <= w;
    repeat (3) @(posedge aclk);
    check("abort_frame", 34'(abort_frame), 34'(e));
    check("tx_pin", 34'(tx_pin), 34'(e));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_MC0, {RESP_OKAY, 24'h0, MC0_RST});
    rd(OFS_BT1, {RESP_OKAY, 24'h0, BT1_RST});
    rd(12'h109, {RESP_SLVERR, 32'h0});
    d = rnd();
    prot <= d[2:0];
    wr(OFS_TXC, d[7:0]);
    rd(OFS_TXC, {RESP_OKAY, 24'h0, d[7:0]});
    // low strobe bit clear: the byte must not land
    strb <= 4'hE;
    wr(OFS_TXC, ~d[7:0]);
    strb <= 4'hF;
    rd(OFS_TXC, {RESP_OKAY, 24'h0, d[7:0]});
    $display("test register map done");
    // background buffer hidden outside test mode
    @(posedge aclk);
    rx_wr_en <= 1'b1;
    rx_wr_idx <= 4'h3;
    rx_wr_data <= d[15:8];
    @(posedge aclk);
    rx_wr_en <= 1'b0;
    rd(OFS_RXBG + 12'h003, {RESP_OKAY, 32'h0});
    wr(OFS_MC0, 8'h04);
    rd(OFS_RXBG + 12'h003, {RESP_OKAY, 24'h0, d[15:8]});
    $display("test background buffer done");
    // random legal timing; pass 0 uses the oscillator, last pass link disabled
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      p = d[1:0];
      t1 = 4'(3 + d[11:8] % 13);
      t2 = 3'(1 + d[14:12] % 7);
      csel = (i != 0);
      ec = (int'(p) + 1) * (int'(t1) + int'(t2) + 3) * (csel ? 1 : 2);
      wr(OFS_MC1, {6'h0, csel, 1'b0});
      wr(OFS_BT0, {2'b00, 4'h0, p});
      wr(OFS_BT1, {1'b0, t2, t1});
      wr(OFS_MC0, {6'h0, i != 3, 1'b0});
      link_len(i != 3 ? ec : 0);
    end
    $display("test bit timing and link done");
    // power-down entry conditions, pin protection and refused access
    engine_tx <= 1'b0;
    pd_step(1'b0, 1'b1, 1'b0);
    pd_step(1'b0, 1'b0, 1'b0);
    wr(OFS_MC1, 8'h04);
    pd_step(1'b0, 1'b1, 1'b1);
    pd_step(1'b0, 1'b0, 1'b0);
    pd_step(1'b1, 1'b0, 1'b1);
    fork
      rd(OFS_MC1, {RESP_OKAY, 24'h0, 8'h04});
      begin
        n = 0;
        repeat (20) begin
          @(posedge aclk);
          if (arready !== 1'b0 || rvalid !== 1'b0) n++;
        end
        check("pd_access", 34'(n), 34'h0);
        cpu_stop <= 1'b0;
      end
    join
    engine_tx <= 1'b1;
    $display("test power-down done");
    // sleep with wakeup filter: short glitch ignored, long activity wakes
    wr(OFS_MC1, 8'h01);
    wr(OFS_MC0, 8'h01);
    rd(OFS_STAT, {RESP_OKAY, 32'h1});
    // stop while asleep: pin stays recessive and sleep survives
    pd_step(1'b1, 1'b0, 1'b1);
    cpu_stop <= 1'b0;
    rd(OFS_STAT, {RESP_OKAY, 32'h1});
    node.drive_dominant(20);
    rd(OFS_STAT, {RESP_OKAY, 32'h1});
    node.drive_dominant(600);
    rd(OFS_STAT, {RESP_OKAY, 32'h2});
    check("wakeup_irq", 34'(wake_irq), 34'h0);
    // clear the wake flag, enable the interrupt, wake unfiltered
    wr(OFS_STAT, 8'h02);
    rd(OFS_STAT, {RESP_OKAY, 32'h0});
    wr(OFS_MC1, 8'h08);
    wr(OFS_MC0, 8'h01);
    node.drive_dominant(3);
    rd(OFS_STAT, {RESP_OKAY, 32'h2});
    check("wakeup_irq", 34'(wake_irq), 34'h1);
    $display("test wakeup filter done");
    end_sim();
  end
endmodule
